// file: verilog/lcdc_pkg.sv
// package: command codes, field layouts, reset values and carrier types
package lcdc_pkg;
  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  localparam logic [6:0] OP7_DISP_ON    = 7'h57;
  localparam logic [6:0] OP7_SEG_DIR    = 7'h50;
  localparam logic [6:0] OP7_INVERT     = 7'h53;
  localparam logic [6:0] OP7_ALL_ON     = 7'h52;
  localparam logic [6:0] OP7_BIAS       = 7'h51;
  localparam logic [6:0] OP7_INDICATOR  = 7'h56;
  localparam logic [1:0] OP2_START_LINE = 2'h1;
  localparam logic [3:0] OP4_PAGE       = 4'hb;
  localparam logic [3:0] OP4_COL_HI     = 4'h1;
  localparam logic [3:0] OP4_COL_LO     = 4'h0;
  localparam logic [3:0] OP4_COM_DIR    = 4'hc;
  localparam logic [3:0] OP4_TEST       = 4'hf;
  localparam logic [4:0] OP5_POWER      = 5'h05;
  localparam logic [4:0] OP5_REG_RATIO  = 5'h04;
  localparam logic [7:0] CMD_RMW        = 8'he0;
  localparam logic [7:0] CMD_END        = 8'hee;
  localparam logic [7:0] CMD_RESET      = 8'he2;
  localparam logic [7:0] CMD_NOP        = 8'he3;
  localparam logic [7:0] CMD_VOLUME     = 8'h81;
  localparam logic [7:0] CMD_BOOSTER    = 8'hf8;
  // ----------------------------------------------------------------------
  // field positions and sizes
  // ----------------------------------------------------------------------
  localparam int COM_DIR_BIT  = 3;
  localparam int PAGE_W       = 4;
  localparam int COL_W        = 8;
  localparam int NUM_PAGES    = 8;
  localparam int NUM_COLS     = 132;
  localparam int RAM_AW       = 11;
  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [5:0] RST_VOLUME   = 6'h20;
  localparam logic [1:0] RST_BOOSTER  = 2'h0;
  localparam logic [2:0] RST_POWER    = 3'h0;
  localparam logic [2:0] RST_REG      = 3'h0;
  localparam logic [1:0] RST_FLASH    = 2'h0;
  localparam logic [7:0] STATUS_LOW   = 8'h00;

  // host bus byte: select line high marks display data
  typedef struct packed {
    logic       is_data;
    logic       is_read;
    logic [7:0] wdata;
  } lcdc_req_t;

  // display and drive settings
  typedef struct packed {
    logic       disp_on;
    logic       seg_rev;
    logic       invert;
    logic       all_on;
    logic       bias_1_7;
    logic       com_rev;
    logic       power_save;
    logic       ind_on;
    logic [1:0] ind_flash;
    logic [5:0] start_line;
    logic [2:0] power_mode;
    logic [2:0] reg_ratio;
    logic [5:0] volume;
    logic [1:0] booster;
  } lcdc_cfg_t;

  typedef enum logic [1:0] {
    ARG_NONE, ARG_VOLUME, ARG_INDICATOR, ARG_BOOSTER
  } lcdc_arg_t;
endpackage : lcdc_pkg

// file: verilog/lcdc_skid.sv
// two-entry buffer between host requests and the decoder
`timescale 1ns/1ps
module lcdc_skid (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // fill side
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire lcdc_pkg::lcdc_req_t in_data,
  // drain side
  output logic                    out_valid,
  input  wire logic               out_ready,
  output lcdc_pkg::lcdc_req_t     out_data
);
  lcdc_pkg::lcdc_req_t mem_q [2];
  logic                wr_q;
  logic                rd_q;
  logic [1:0]          cnt_q;

  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge mclk) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= ~wr_q;
      end
      if (out_valid && out_ready) begin
        rd_q <= ~rd_q;
      end
      case ({in_valid && in_ready, out_valid && out_ready})
        2'b10:   cnt_q <= cnt_q + 2'd1;
        2'b01:   cnt_q <= cnt_q - 2'd1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  a_skid_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    cnt_q <= 2'd2) else $error("buffer count out of range");
endmodule // lcdc_skid

// file: verilog/lcdc_ram.sv
// display ram: eight pages of 132 columns, one byte per cell
`timescale 1ns/1ps
module lcdc_ram (
  // clock
  input  wire logic        mclk,
  // port
  input  wire logic        we,
  input  wire logic [10:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  logic [7:0] cells [lcdc_pkg::NUM_PAGES * lcdc_pkg::NUM_COLS];

  always_ff @(posedge mclk) begin
    if (we) begin
      cells[addr] <= wdata;
    end
    rdata <= cells[addr];
  end
endmodule // lcdc_ram

// file: verilog/lcdc_decoder.sv
// command decoder of a 128x64 dot-matrix display controller
// Functional notes
// - 0xae/0xaf turn display off/on
// - 01xxxxxx sets display start line
// - 1011xxxx sets ram page pointer
// - 0001/0000 nibbles set column high/low
// - status read: flags high, zeros low
// - data write stores at page/column
// - data read returns byte at page/column
// - 1010000x sets segment mapping direction
// - 1010011x selects normal or inverted pixels
// - 1010010x forces all pixels on
// - 1010001x selects bias 1/9 or 1/7
// - read-modify-write: writes advance, reads hold
// - 1100xxxx bit3 sets common scan direction
// - 00101xxx sets power supply mode
// - 00100xxx sets regulator resistor ratio
// - 0x81 then next byte is volume
// - indicator on/off then flashing mode byte
// - 0xf8 then byte selects booster ratio
// - display off plus all-on enters power save
// - select high is data, low command
`timescale 1ns/1ps
module lcdc_decoder (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // host byte strobe
  input  wire logic               host_valid,
  output logic                    host_ready,
  input  wire logic               cmd_data_select,
  input  wire logic               host_read,
  input  wire logic [7:0]         host_wdata,
  // read answer
  output logic                    rd_valid,
  output logic      [7:0]         rd_data,
  // live status flags
  input  wire logic               busy_flag,
  input  wire logic               reset_flag,
  // settings out
  output lcdc_pkg::lcdc_cfg_t     cfg,
  output logic      [3:0]         page_ptr,
  output logic      [7:0]         col_ptr,
  output logic                    rmw_active
);
  // ----------------------------------------------------------------------
  // request buffer
  // ----------------------------------------------------------------------
  lcdc_pkg::lcdc_req_t in_req;
  lcdc_pkg::lcdc_req_t req;
  logic                req_valid;
  logic                req_ready;
  logic                rd_pend_q;

  assign in_req = '{is_data: cmd_data_select, is_read: host_read,
                    wdata: host_wdata};

  lcdc_skid u_skid (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (host_valid),
    .in_ready  (host_ready),
    .in_data   (in_req),
    .out_valid (req_valid),
    .out_ready (req_ready),
    .out_data  (req)
  );

  // ram read takes a cycle: stall the next request while it completes
  assign req_ready = !rd_pend_q;

  logic       fire;
  logic       cmd_wr;
  logic       dat_wr;
  logic       dat_rd;
  logic       sta_rd;
  logic [7:0] b;

  assign fire   = req_valid && req_ready;
  assign b      = req.wdata;
  assign cmd_wr = fire && !req.is_data && !req.is_read;
  assign dat_wr = fire &&  req.is_data && !req.is_read;
  assign dat_rd = fire &&  req.is_data &&  req.is_read;
  assign sta_rd = fire && !req.is_data &&  req.is_read;

  // ----------------------------------------------------------------------
  // two-byte command tracking
  // ----------------------------------------------------------------------
  lcdc_pkg::lcdc_arg_t arg_q;
  logic                arg_cmd;

  assign arg_cmd = cmd_wr && (arg_q != lcdc_pkg::ARG_NONE);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arg_q <= lcdc_pkg::ARG_NONE;
    end else if (cmd_wr) begin
      if (arg_q != lcdc_pkg::ARG_NONE) begin
        arg_q <= lcdc_pkg::ARG_NONE;
      end else if (b == lcdc_pkg::CMD_VOLUME) begin
        arg_q <= lcdc_pkg::ARG_VOLUME;
      end else if (b == lcdc_pkg::CMD_BOOSTER) begin
        arg_q <= lcdc_pkg::ARG_BOOSTER;
      end else if (b[7:1] == lcdc_pkg::OP7_INDICATOR) begin
        arg_q <= lcdc_pkg::ARG_INDICATOR;
      end
    end
  end

  // ----------------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------------
  logic      sreset;
  logic      single;

  assign single = cmd_wr && !arg_cmd;
  assign sreset = single && (b == lcdc_pkg::CMD_RESET);

  // next-state view of display-on and all-on for the power save term
  logic cfg_next_disp;
  logic cfg_next_all;
  always_comb begin
    cfg_next_disp = cfg.disp_on;
    cfg_next_all  = cfg.all_on;
    if (single && b[7:1] == lcdc_pkg::OP7_DISP_ON) begin
      cfg_next_disp = b[0];
    end
    if (single && b[7:1] == lcdc_pkg::OP7_ALL_ON) begin
      cfg_next_all = b[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || sreset) begin
      cfg.disp_on    <= 1'b0;
      cfg.power_save <= 1'b0;
      cfg.seg_rev    <= 1'b0;
      cfg.invert     <= 1'b0;
      cfg.all_on     <= 1'b0;
      cfg.bias_1_7   <= 1'b0;
      cfg.com_rev    <= 1'b0;
      cfg.ind_on     <= 1'b0;
      cfg.ind_flash  <= lcdc_pkg::RST_FLASH;
      cfg.start_line <= '0;
      cfg.power_mode <= lcdc_pkg::RST_POWER;
      cfg.reg_ratio  <= lcdc_pkg::RST_REG;
      cfg.volume     <= lcdc_pkg::RST_VOLUME;
      cfg.booster    <= lcdc_pkg::RST_BOOSTER;
    end else if (arg_cmd) begin
      case (arg_q)
        lcdc_pkg::ARG_VOLUME:    cfg.volume    <= b[5:0];
        lcdc_pkg::ARG_INDICATOR: cfg.ind_flash <= b[1:0];
        lcdc_pkg::ARG_BOOSTER:   cfg.booster   <= b[1:0];
        default:                 cfg.volume    <= cfg.volume;
      endcase
    end else if (single) begin
      if (b[7:1] == lcdc_pkg::OP7_DISP_ON) begin
        cfg.disp_on <= b[0];
      end
      if (b[7:6] == lcdc_pkg::OP2_START_LINE) begin
        cfg.start_line <= b[5:0];
      end
      if (b[7:1] == lcdc_pkg::OP7_SEG_DIR) begin
        cfg.seg_rev <= b[0];
      end
      if (b[7:1] == lcdc_pkg::OP7_INVERT) begin
        cfg.invert <= b[0];
      end
      if (b[7:1] == lcdc_pkg::OP7_ALL_ON) begin
        cfg.all_on <= b[0];
      end
      if (b[7:1] == lcdc_pkg::OP7_BIAS) begin
        cfg.bias_1_7 <= b[0];
      end
      if (b[7:4] == lcdc_pkg::OP4_COM_DIR) begin
        cfg.com_rev <= b[lcdc_pkg::COM_DIR_BIT];
      end
      if (b[7:3] == lcdc_pkg::OP5_POWER) begin
        cfg.power_mode <= b[2:0];
      end
      if (b[7:3] == lcdc_pkg::OP5_REG_RATIO) begin
        cfg.reg_ratio <= b[2:0];
      end
      if (b[7:1] == lcdc_pkg::OP7_INDICATOR) begin
        cfg.ind_on <= b[0];
      end
    end
    // power save holds while display is off and all points are on
    if (rst_n && !sreset) begin
      cfg.power_save <= !cfg_next_disp && cfg_next_all;
    end
  end

  // ----------------------------------------------------------------------
  // pointers and read-modify-write
  // ----------------------------------------------------------------------
  logic [7:0] rmw_save_q;

  always_ff @(posedge mclk) begin
    if (!rst_n || sreset) begin
      rmw_active <= 1'b0;
    end else if (single && b == lcdc_pkg::CMD_RMW) begin
      rmw_active <= 1'b1;
    end else if (single && b == lcdc_pkg::CMD_END) begin
      rmw_active <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || sreset) begin
      page_ptr   <= '0;
      col_ptr    <= '0;
      rmw_save_q <= '0;
    end else if (single) begin
      if (b[7:4] == lcdc_pkg::OP4_PAGE) begin
        page_ptr <= b[3:0];
      end
      if (b[7:4] == lcdc_pkg::OP4_COL_HI) begin
        col_ptr[7:4] <= b[3:0];
      end
      if (b[7:4] == lcdc_pkg::OP4_COL_LO) begin
        col_ptr[3:0] <= b[3:0];
      end
      if (b == lcdc_pkg::CMD_RMW) begin
        rmw_save_q <= col_ptr;
      end
      if (b == lcdc_pkg::CMD_END && rmw_active) begin
        col_ptr <= rmw_save_q;
      end
    end else if (dat_wr) begin
      col_ptr <= col_ptr + 8'd1;
    end else if (dat_rd && !rmw_active) begin
      col_ptr <= col_ptr + 8'd1;
    end
  end

  // ----------------------------------------------------------------------
  // display ram and read answers
  // ----------------------------------------------------------------------
  logic [10:0] ram_addr;
  logic [7:0]  ram_rdata;
  logic        rd_is_ram_q;
  logic [7:0]  status_q;

  assign ram_addr = 11'(page_ptr[2:0] * lcdc_pkg::NUM_COLS) + 11'(col_ptr);

  lcdc_ram u_ram (
    .mclk  (mclk),
    .we    (dat_wr),
    .addr  (ram_addr),
    .wdata (b),
    .rdata (ram_rdata)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_pend_q   <= 1'b0;
      rd_is_ram_q <= 1'b0;
      status_q    <= lcdc_pkg::STATUS_LOW;
    end else begin
      rd_pend_q   <= dat_rd || sta_rd;
      rd_is_ram_q <= dat_rd;
      status_q    <= {busy_flag, cfg.seg_rev, !cfg.disp_on, reset_flag,
                      4'h0};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= rd_pend_q;
      if (rd_pend_q) begin
        rd_data <= rd_is_ram_q ? ram_rdata : status_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_disp_switch: assert property (@(posedge mclk) disable iff (!rst_n)
    single && b[7:1] == lcdc_pkg::OP7_DISP_ON |=> cfg.disp_on == $past(b[0]))
    else $error("display on/off not applied");
  a_start_line: assert property (@(posedge mclk) disable iff (!rst_n)
    single && b[7:6] == lcdc_pkg::OP2_START_LINE
    |=> cfg.start_line == $past(b[5:0]))
    else $error("start line not loaded");
  a_page_load: assert property (@(posedge mclk) disable iff (!rst_n)
    single && b[7:4] == lcdc_pkg::OP4_PAGE |=> page_ptr == $past(b[3:0]))
    else $error("page pointer not loaded");
  a_col_high: assert property (@(posedge mclk) disable iff (!rst_n)
    single && b[7:4] == lcdc_pkg::OP4_COL_HI
    |=> col_ptr[7:4] == $past(b[3:0]))
    else $error("column high nibble not loaded");
  a_status_low: assert property (@(posedge mclk) disable iff (!rst_n)
    sta_rd |-> ##2 rd_valid && rd_data[3:0] == 4'h0)
    else $error("status low nibble not zero");
  a_status_flags: assert property (@(posedge mclk) disable iff (!rst_n)
    sta_rd |-> ##2 rd_data[7] == $past(busy_flag, 2)
    && rd_data[4] == $past(reset_flag, 2))
    else $error("status flags not reported");
  a_rd_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    dat_rd |-> ##2 rd_valid)
    else $error("data read not answered");
  a_data_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    dat_wr |=> $stable(cfg))
    else $error("data byte changed settings");
  a_rmw_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    dat_rd && rmw_active |=> $stable(col_ptr))
    else $error("column moved on rmw read");
  a_wr_advance: assert property (@(posedge mclk) disable iff (!rst_n)
    dat_wr |=> col_ptr == $past(col_ptr) + 8'd1)
    else $error("column did not advance on write");
  a_volume_arg: assert property (@(posedge mclk) disable iff (!rst_n)
    arg_cmd && arg_q == lcdc_pkg::ARG_VOLUME
    |=> cfg.volume == $past(b[5:0]))
    else $error("volume byte not taken");
  a_flash_arg: assert property (@(posedge mclk) disable iff (!rst_n)
    arg_cmd && arg_q == lcdc_pkg::ARG_INDICATOR
    |=> cfg.ind_flash == $past(b[1:0]))
    else $error("flash mode byte not taken");
  a_booster_arg: assert property (@(posedge mclk) disable iff (!rst_n)
    arg_cmd && arg_q == lcdc_pkg::ARG_BOOSTER
    |=> cfg.booster == $past(b[1:0]))
    else $error("booster byte not taken");
  a_power_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    single && b[7:3] == lcdc_pkg::OP5_POWER
    |=> cfg.power_mode == $past(b[2:0]))
    else $error("power mode not loaded");
  a_com_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    single && b[7:4] == lcdc_pkg::OP4_COM_DIR
    |=> cfg.com_rev == $past(b[3]))
    else $error("scan direction not set");
  a_save_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg.power_save |-> !cfg.disp_on && cfg.all_on)
    else $error("power save without its settings");
  a_nop_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    single && b == lcdc_pkg::CMD_NOP |=> $stable(cfg) && $stable(col_ptr))
    else $error("nop changed state");

  c_rmw_cycle: cover property (@(posedge mclk) disable iff (!rst_n)
    rmw_active ##[1:40] !rmw_active);
  c_booster: cover property (@(posedge mclk) disable iff (!rst_n)
    arg_cmd && arg_q == lcdc_pkg::ARG_BOOSTER);
  c_data_read: cover property (@(posedge mclk) disable iff (!rst_n)
    dat_rd ##2 rd_valid);
  c_volume: cover property (@(posedge mclk) disable iff (!rst_n)
    arg_cmd && arg_q == lcdc_pkg::ARG_VOLUME);
  c_power_save: cover property (@(posedge mclk) disable iff (!rst_n)
    cfg.power_save);
endmodule // lcdc_decoder

// file: bench/lcdc_host_model.sv
// host model: offers bus bytes to the decoder and holds each until taken
`timescale 1ns/1ps
module lcdc_host_model (
  // clock
  input  wire logic       mclk,
  // byte bus toward the decoder
  output logic            host_valid,
  input  wire logic       host_ready,
  output logic            cmd_data_select,
  output logic            host_read,
  output logic [7:0]      host_wdata
);
  int refused = 0;

  initial begin
    host_valid      = 1'b0;
    cmd_data_select = 1'b0;
    host_read       = 1'b0;
    host_wdata      = 8'h00;
  end

  // ----------------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------------
  // argument bytes follow their lead command after five idle cycles
  task automatic send(input logic sel, input logic rd, input logic [7:0] b);
    host_valid      = 1'b1;
    cmd_data_select = sel;
    host_read       = rd;
    host_wdata      = b;
    while (host_ready !== 1'b1) begin
      refused++;
      @(posedge mclk);
      #2;
    end
    @(posedge mclk);
    #2;
  endtask

  // released bus: data lines stop showing the last byte
  task automatic idle();
    host_valid = 1'b0;
    host_wdata = ~host_wdata;
    @(posedge mclk);
    #2;
  endtask
endmodule // lcdc_host_model

// file: bench/tb_top.sv
// testbench: command decoder driven by the host model
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic [7:0] cmd;
    int         off;
    int         wid;
    logic [7:0] val;
  } lcdc_row_t;

  logic                mclk = 1'b0;
  logic                rst_n = 1'b0;
  logic                busy_flag = 1'b0;
  logic                reset_flag = 1'b0;
  logic                host_valid, host_ready, cmd_data_select, host_read;
  logic [7:0]          host_wdata, rd_data, col_ptr;
  logic                rd_valid, rmw_active;
  logic [3:0]          page_ptr;
  lcdc_pkg::lcdc_cfg_t cfg, rv;
  logic [41:0]         view;
  logic [7:0]          rq[$];
  int                  failures = 0;
  int                  cmp_count = 0;
  lcdc_row_t           rows[31];

  assign view = {cfg, page_ptr, col_ptr};
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (rd_valid === 1'b1) rq.push_back(rd_data);

  lcdc_host_model host_u (
    .mclk(mclk), .host_valid(host_valid), .host_ready(host_ready),
    .cmd_data_select(cmd_data_select), .host_read(host_read),
    .host_wdata(host_wdata));

  lcdc_decoder dut_u (
    .mclk(mclk), .rst_n(rst_n), .host_valid(host_valid),
    .host_ready(host_ready), .cmd_data_select(cmd_data_select),
    .host_read(host_read), .host_wdata(host_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .busy_flag(busy_flag), .reset_flag(reset_flag),
    .cfg(cfg), .page_ptr(page_ptr), .col_ptr(col_ptr),
    .rmw_active(rmw_active));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (5) host_u.idle();
  endtask

  task automatic cmd(input logic [7:0] b);
    host_u.send(1'b0, 1'b0, b);
    settle();
  endtask

  task automatic rd(input logic sel);
    host_u.send(sel, 1'b1, 8'h00);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    results();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    rows = '{
      '{8'haf, 41, 1, 8'h01},
      '{8'hae, 41, 1, 8'h00},
      '{8'h6a, 26, 6, 8'h2a},
      '{8'hb5, 8, 4, 8'h05},
      '{8'h13, 0, 8, 8'h30},
      '{8'h0a, 0, 8, 8'h3a},
      '{8'ha1, 40, 1, 8'h01},
      '{8'ha0, 40, 1, 8'h00},
      '{8'ha7, 39, 1, 8'h01},
      '{8'ha6, 39, 1, 8'h00},
      '{8'ha5, 38, 1, 8'h01},
      '{8'he3, 35, 1, 8'h01},
      '{8'ha4, 38, 1, 8'h00},
      '{8'ha3, 37, 1, 8'h01},
      '{8'ha2, 37, 1, 8'h00},
      '{8'hc8, 36, 1, 8'h01},
      '{8'hc7, 36, 1, 8'h00},
      '{8'h2d, 23, 3, 8'h05},
      '{8'h23, 20, 3, 8'h03},
      '{8'h81, 14, 6, 8'h20},
      '{8'h15, 14, 6, 8'h15},
      '{8'had, 34, 1, 8'h01},
      '{8'h02, 32, 2, 8'h02},
      '{8'hac, 34, 1, 8'h00},
      '{8'h01, 32, 2, 8'h01},
      '{8'hf8, 12, 2, 8'h00},
      '{8'h03, 12, 2, 8'h03},
      '{8'hf8, 12, 2, 8'h03},
      '{8'h01, 12, 2, 8'h01},
      '{8'hf8, 12, 2, 8'h01},
      '{8'h00, 12, 2, 8'h00}};
    rv = '0;
    rv.volume = lcdc_pkg::RST_VOLUME;
    repeat (5) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    host_u.idle();
    chk(view, {rv, 12'h000});
    foreach (rows[i]) begin
      cmd(rows[i].cmd);
      chk((view >> rows[i].off) & ((42'h1 << rows[i].wid) - 42'h1),
          {34'h0, rows[i].val});
    end
    // data writes back to back, a data byte equal to display off
    cmd(8'haf);
    cmd(8'hb2);
    cmd(8'h10);
    cmd(8'h05);
    host_u.send(1'b1, 1'b0, 8'h3c);
    host_u.send(1'b1, 1'b0, 8'hae);
    host_u.send(1'b1, 1'b0, 8'h5a);
    host_u.send(1'b1, 1'b0, 8'h81);
    settle();
    chk(col_ptr, 8'h09);
    chk(cfg.disp_on, 1'b1);
    // reads back to back fill the buffer
    cmd(8'h05);
    rq.delete();
    repeat (4) rd(1'b1);
    settle();
    chk(rq.size(), 4);
    chk({rq[0], rq[1], rq[2], rq[3]}, 32'h3cae5a81);
    chk(host_u.refused > 0, 1'b1);
    // read-modify-write
    cmd(8'h05);
    cmd(8'he0);
    chk(rmw_active, 1'b1);
    rq.delete();
    rd(1'b1);
    settle();
    chk(col_ptr, 8'h05);
    host_u.send(1'b1, 1'b0, 8'h55);
    settle();
    chk(col_ptr, 8'h06);
    cmd(8'hee);
    chk({rmw_active, col_ptr}, 9'h005);
    rd(1'b1);
    settle();
    chk({rq[0], rq[1]}, 16'h3c55);
    // status byte
    rq.delete();
    busy_flag = 1'b1;
    rd(1'b0);
    settle();
    busy_flag = 1'b0;
    reset_flag = 1'b1;
    cmd(8'ha1);
    cmd(8'hae);
    rd(1'b0);
    settle();
    chk({rq[0], rq[1]}, 16'h8070);
    // internal reset command
    cmd(8'he2);
    chk(view, {rv, 12'h000});
    // reset pin in mid-run
    cmd(8'haf);
    rst_n = 1'b0;
    host_u.idle();
    host_u.idle();
    rst_n = 1'b1;
    host_u.idle();
    chk({view, rmw_active, rd_valid}, {rv, 14'h0});
    results();
  end
endmodule // tb_top
